// File: rtl/fps_pkg.sv
// Purpose: Constants for the flash protection and security register block.
// Assumes: APB slave, 32-bit data, byte addresses within the block.
// Notes:   Offsets are byte addresses relative to the block base.
package fps_pkg;
  localparam logic [11:0] OFF_SEC_CTRL   = 12'h010;
  localparam logic [11:0] OFF_FLASH_STAT = 12'h020;
  localparam logic [11:0] OFF_IRQ_STAT   = 12'h030;
  localparam logic [11:0] OFF_IRQ_EN     = 12'h034;
  localparam logic [11:0] OFF_IRQ_CLR    = 12'h038;
  localparam logic [31:0] UNLOCK_CODE    = 32'hA74A9D23;
  localparam int          UNLOCK_WINDOW  = 16;
  localparam int          PROT_LSB       = 16;
  localparam int          READY_BIT      = 0;
  localparam int          SEC_BIT        = 0;
  localparam logic        SEC_RESET      = 1'b1;
  localparam int          IRQ_OP_DONE    = 0;
  localparam int          IRQ_OP_FAIL    = 1;
  localparam int          IRQ_REJECT     = 2;
  localparam int          IRQ_W          = 3;
  localparam int          CLK_HZ         = 25000000;
  localparam int          RECOVER_RST_US = 500;
  localparam int          READ_READY_US  = 2000;
  localparam int          RECOVER_RST_CYC = (RECOVER_RST_US * (CLK_HZ / 1000000));
  localparam int          READ_READY_CYC  = (READ_READY_US * (CLK_HZ / 1000000));
  typedef enum logic [2:0] {
    FPS_UNLOCK_IDLE  = 3'b001,
    FPS_UNLOCK_OPEN  = 3'b010,
    FPS_UNLOCK_DUMMY = 3'b100
  } fps_unlock_e;
endpackage : fps_pkg

// File: rtl/fps_regs.sv
// Purpose: Flash protection/status and security-enable registers on APB.
// Assumes: Flash sequencer supplies protection flags and busy/fail on pclk.
// Notes:   Status bits are hardware-driven; only security bit, IRQ enable and IRQ clear are writable.
//
// Contract
// RULE_01 - Security at 0x10, status at 0x20
// RULE_02 - Six blocks: bits 21:16, above zero
// RULE_03 - Four blocks: bits 19:16, above zero
// RULE_04 - Reject writes to protected blocks
// RULE_05 - Bit 0 ready, bits 15:1 zero
// RULE_06 - Failure holds busy until hardware reset
// RULE_07 - Software commands only while ready; secure-mode protect erase is taken even when not ready
// RULE_08 - Recovery needs 0.5 ms reset, 2 ms
// RULE_09 - Security bit R/W, set on resets
// RULE_10 - Security active: bit and all flags
// RULE_11 - Unlock code then write within 16
// RULE_12 - Secure: refuse commands, debug; erase all
// RULE_13 - Read-only and reserved writes ignored
//
// Design decision made here: the APB interface to the registers.
module fps_regs #(
  parameter int NUM_BLOCKS = 6
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  deep_standby_exit,
  input  wire logic [NUM_BLOCKS-1:0] block_protect_flag,
  input  wire logic                  auto_op_busy,
  input  wire logic                  auto_op_fail,
  input  wire logic                  cmd_req,
  input  wire logic [2:0]            cmd_block,
  input  wire logic                  cmd_is_prot_erase,
  output logic                       cmd_accept,
  output logic                       cmd_reject,
  output logic                       prot_erase_all,
  output logic                       security_active,
  output logic                       debug_block,
  output logic                       auto_op_ready_flag,
  output logic                       irq
);
  import fps_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  security_enable;
    fps_unlock_e           unlock;
    logic [4:0]            unlock_cnt;
    logic [NUM_BLOCKS-1:0] prot;
    logic                  ready;
    logic                  failed;
    logic                  busy_d;
    logic                  cmd_accept;
    logic                  cmd_reject;
    logic                  erase_all;
    logic                  sec_active;
    logic                  dbg_block;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_en;
    logic                  irq;
  } fps_state_s;

  fps_state_s st_reg, st_next;

  wire logic access = psel & penable;
  wire logic wr     = access & pwrite;
  wire logic full32 = (pstrb == 4'hF);

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             blk_prot;
    ev       = '0;
    clr      = '0;
    blk_prot = 1'b0;
    st_next  = st_reg;

    // ---------------------------------------------------------------
    // Hardware status
    // ---------------------------------------------------------------
    st_next.prot   = block_protect_flag;                    // [RULE_04]
    st_next.busy_d = auto_op_busy;
    if (auto_op_busy && auto_op_fail) begin
      st_next.failed = 1'b1;                                // [RULE_06]
    end
    // Failure latches busy; only reset clears it
    st_next.ready = ~auto_op_busy & ~st_next.failed;        // [RULE_05] [RULE_06]
    ev[IRQ_OP_DONE] = st_reg.busy_d & ~auto_op_busy & ~st_next.failed;
    ev[IRQ_OP_FAIL] = ~st_reg.failed & st_next.failed;

    st_next.sec_active = st_reg.security_enable & (&st_reg.prot);  // [RULE_10]
    st_next.dbg_block  = st_next.sec_active;                       // [RULE_12]

    // ---------------------------------------------------------------
    // Command gate toward the sequencer
    // ---------------------------------------------------------------
    st_next.cmd_accept = 1'b0;
    st_next.cmd_reject = 1'b0;
    st_next.erase_all  = 1'b0;
    if (cmd_req) begin
      if (cmd_block < 3'(NUM_BLOCKS)) begin
        blk_prot = st_reg.prot[cmd_block];
      end
      if (st_reg.sec_active && cmd_is_prot_erase) begin
        st_next.erase_all = 1'b1;                           // [RULE_12]
      end else if (st_reg.sec_active || !st_reg.ready || (blk_prot && !cmd_is_prot_erase)) begin
        // Busy commands are refused, not queued, to avoid lockup
        st_next.cmd_reject = 1'b1;                          // [RULE_04] [RULE_07] [RULE_12]
        ev[IRQ_REJECT]     = 1'b1;
      end else begin
        st_next.cmd_accept = 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // Security unlock sequence
    // ---------------------------------------------------------------
    case (st_reg.unlock)
      FPS_UNLOCK_IDLE: begin
        st_next.unlock_cnt = '0;
      end
      FPS_UNLOCK_OPEN: begin
        if (st_reg.unlock_cnt >= 5'(UNLOCK_WINDOW - 1)) begin
          st_next.unlock = FPS_UNLOCK_IDLE;                 // [RULE_11]
        end else begin
          st_next.unlock_cnt = st_reg.unlock_cnt + 5'd1;
        end
      end
      default: st_next.unlock = FPS_UNLOCK_IDLE;
    endcase

    // ---------------------------------------------------------------
    // APB slave, zero wait states
    // ---------------------------------------------------------------
    st_next.pready  = psel & ~penable;
    st_next.pslverr = 1'b0;
    st_next.prdata  = '0;
    if (psel && !penable) begin
      case (paddr)
        OFF_SEC_CTRL:   st_next.prdata[SEC_BIT] = st_reg.security_enable;   // [RULE_01] [RULE_09]
        OFF_FLASH_STAT: begin
          st_next.prdata[PROT_LSB +: NUM_BLOCKS] = st_reg.prot;  // [RULE_02] [RULE_03]
          st_next.prdata[READY_BIT]              = st_reg.ready; // [RULE_05]
        end
        OFF_IRQ_STAT:   st_next.prdata[IRQ_W-1:0] = st_reg.irq_stat;
        OFF_IRQ_EN:     st_next.prdata[IRQ_W-1:0] = st_reg.irq_en;
        default:        st_next.prdata = '0;                // [RULE_13]
      endcase
    end
    if (wr) begin
      case (paddr)
        OFF_SEC_CTRL: begin
          if (full32 && pwdata == UNLOCK_CODE) begin
            st_next.unlock     = FPS_UNLOCK_OPEN;           // [RULE_11]
            st_next.unlock_cnt = '0;
          end else begin
            if (full32 && st_reg.unlock == FPS_UNLOCK_OPEN) begin
              st_next.security_enable = pwdata[SEC_BIT];    // [RULE_09] [RULE_11]
            end
            st_next.unlock = FPS_UNLOCK_IDLE;
          end
        end
        OFF_IRQ_EN:  st_next.irq_en = pwdata[IRQ_W-1:0];
        OFF_IRQ_CLR: clr = pwdata[IRQ_W-1:0];
        default: ;                                          // [RULE_13]
      endcase
    end

    // Set wins over clear
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg                 <= '0;
      st_reg.security_enable <= SEC_RESET;                  // [RULE_09]
      st_reg.unlock          <= FPS_UNLOCK_IDLE;
      st_reg.ready           <= 1'b1;                       // [RULE_06] [RULE_08]
    end else begin
      st_reg <= st_next;
      // Leaving deepest standby restores security
      if (deep_standby_exit) begin
        st_reg.security_enable <= SEC_RESET;                // [RULE_09]
        st_reg.unlock          <= FPS_UNLOCK_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata             = st_reg.prdata;
  assign pready             = st_reg.pready;
  assign pslverr            = st_reg.pslverr;
  assign cmd_accept         = st_reg.cmd_accept;
  assign cmd_reject         = st_reg.cmd_reject;
  assign prot_erase_all     = st_reg.erase_all;
  assign security_active    = st_reg.sec_active;
  assign debug_block        = st_reg.dbg_block;
  assign auto_op_ready_flag = st_reg.ready;
  assign irq                = st_reg.irq;
endmodule : fps_regs

// File: tb/fps_regs_asserts.sv
// Purpose: Bus and command checks on the ports of fps_regs.
// Assumes: Zero wait-state APB; command replies one cycle after cmd_req.
// Notes:   Ready flag lags busy by one register stage; security_active lags the protect flags by two.
module fps_regs_asserts
  import fps_pkg::*;
#(
  parameter int NUM_BLOCKS = 6
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic [NUM_BLOCKS-1:0] block_protect_flag,
  input wire logic                  auto_op_busy,
  input wire logic                  auto_op_ready_flag,
  input wire logic                  cmd_req,
  input wire logic [2:0]            cmd_block,
  input wire logic                  cmd_is_prot_erase,
  input wire logic                  cmd_reject,
  input wire logic                  security_active
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite;
  wire logic wr_cmd = cmd_req && !cmd_is_prot_erase;
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no pready after setup");
  property p_stat_zero;
    rd && paddr == OFF_FLASH_STAT |-> (prdata >> (16 + NUM_BLOCKS)) == 0 && prdata[15:1] == 0;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
  property p_sec_zero; rd && paddr == OFF_SEC_CTRL |-> prdata[31:1] == 0; endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("security spare bits set");
  property p_busy; auto_op_busy |=> !auto_op_ready_flag; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_busy_rej; wr_cmd && !auto_op_ready_flag |=> cmd_reject; endproperty
  a_busy_rej: assert property (p_busy_rej) else $error("busy command taken");
  property p_sec_rej; wr_cmd && security_active |=> cmd_reject; endproperty
  a_sec_rej: assert property (p_sec_rej) else $error("secure command taken");
  property p_prot_rej;
    wr_cmd && cmd_block < NUM_BLOCKS && block_protect_flag[cmd_block] |=> cmd_reject;
  endproperty
  a_prot_rej: assert property (p_prot_rej) else $error("protected write taken");
  property p_sec_flags; security_active |-> $past(&block_protect_flag, 2); endproperty
  a_sec_flags: assert property (p_sec_flags) else $error("secure without flags");
  c_secure: cover property (security_active);
  c_rej: cover property (cmd_req ##1 cmd_reject);
  c_stat: cover property (rd && paddr == OFF_FLASH_STAT);
endmodule : fps_regs_asserts
bind fps_regs fps_regs_asserts #(.NUM_BLOCKS(NUM_BLOCKS)) u_fps_regs_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .block_protect_flag,
  .auto_op_busy, .auto_op_ready_flag, .cmd_req, .cmd_block, .cmd_is_prot_erase, .cmd_reject,
  .security_active);

// File: tb/fps_regs_bench.sv
// Purpose: Self-checking bench for fps_regs.
// Assumes: Zero wait-state APB; command replies one cycle after cmd_req.
// Notes:   Read data and command replies are checked from one queue.
module fps_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fps_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, deep_standby_exit = '0;
  logic auto_op_busy = '0, auto_op_fail = '0, cmd_req = '0, cmd_is_prot_erase = '0;
  logic pready, pslverr, cmd_accept, cmd_reject, prot_erase_all, security_active, rdy, irq, dbg;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, lf = 32'h25457410, q[$];
  logic [2:0]  cmd_block = '0;
  logic [5:0]  flags = '0;
  logic [44:0] ops[13] = '{45'h1_010_00000000, 45'h0_010_00000001, 45'h1_010_A74A9D23,
    45'h1_010_00000000, 45'h0_010_00000000, 45'h1_010_00000001, 45'h0_010_00000000,
    45'h1_014_FFFFFFFF, 45'h1_020_FFFFFFFF, 45'h0_014_00000000, 45'h1_010_A74A9D23,
    45'h1_010_00000001, 45'h0_010_00000001};
  int mismatches = 0, cmp_count = 0, cyc = 0;
  fps_regs u_fps_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .deep_standby_exit, .block_protect_flag(flags),
    .auto_op_busy, .auto_op_fail, .cmd_req, .cmd_block, .cmd_is_prot_erase, .cmd_accept,
    .cmd_reject, .prot_erase_all, .security_active, .debug_block(dbg), .auto_op_ready_flag(rdy),
    .irq);
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // ----------------------------------------
  // Drivers; reads queue their expected data
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(d);
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic cmd(input logic [2:0] b, input logic e, input logic [31:0] x);
    @(posedge pclk);
    cmd_req <= 1'h1;
    cmd_block <= b;
    cmd_is_prot_erase <= e;
    q.push_back(x);
    @(posedge pclk);
    cmd_req <= 1'h0;
    @(posedge pclk);
  endtask : cmd
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite) chk(prdata, q.pop_front());
    if (cmd_accept || cmd_reject || prot_erase_all)
      chk({29'h0, cmd_accept, cmd_reject, prot_erase_all}, q.pop_front());
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    flags <= lf[5:0];
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFF_SEC_CTRL, 32'h1);
    apb(1'h0, OFF_FLASH_STAT, {10'h0, flags, 16'h1});
    foreach (ops[i]) apb(ops[i][44], ops[i][43:32], ops[i][31:0]);
    apb(1'h0, OFF_FLASH_STAT, {10'h0, flags, 16'h1});
    apb(1'h1, OFF_SEC_CTRL, UNLOCK_CODE);
    repeat (UNLOCK_WINDOW) @(posedge pclk);
    apb(1'h1, OFF_SEC_CTRL, 32'h0);
    apb(1'h0, OFF_SEC_CTRL, 32'h1);
    apb(1'h1, OFF_SEC_CTRL, UNLOCK_CODE);
    apb(1'h1, OFF_SEC_CTRL, 32'h0);
    deep_standby_exit <= 1'h1;
    @(posedge pclk);
    deep_standby_exit <= 1'h0;
    flags <= 6'h01;
    apb(1'h0, OFF_SEC_CTRL, 32'h1);
    $display("register test done");
    apb(1'h1, OFF_IRQ_EN, 32'h4);
    cmd(3'h0, 1'h0, 32'h2);
    apb(1'h0, OFF_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, OFF_IRQ_EN, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    apb(1'h1, OFF_IRQ_CLR, 32'h4);
    apb(1'h0, OFF_IRQ_STAT, 32'h0);
    cmd(3'h1, 1'h0, 32'h4);
    auto_op_busy <= 1'h1;
    apb(1'h0, OFF_FLASH_STAT, {10'h0, 6'h01, 16'h0});
    cmd(3'h1, 1'h0, 32'h2);
    auto_op_fail <= 1'h1;
    @(posedge pclk);
    auto_op_busy <= 1'h0;
    auto_op_fail <= 1'h0;
    apb(1'h0, OFF_FLASH_STAT, {10'h0, 6'h01, 16'h0});
    presetn <= 1'h0;
    repeat (RECOVER_RST_CYC) @(posedge pclk);
    presetn <= 1'h1;
    flags <= 6'h3F;
    apb(1'h0, OFF_FLASH_STAT, {10'h0, 6'h3F, 16'h1});
    chk({31'h0, rdy}, 32'h1);
    $display("command test done");
    chk({31'h0, security_active}, 32'h1);
    chk({31'h0, dbg}, 32'h1);
    cmd(3'h2, 1'h0, 32'h2);
    cmd(3'h0, 1'h1, 32'h1);
    flags <= 6'h3E;
    repeat (3) @(posedge pclk);
    chk({31'h0, security_active}, 32'h0);
    chk({31'h0, dbg}, 32'h0);
    $display("security test done");
    give_verdict();
  end
endmodule : fps_regs_bench
